/* src/tbdi_top.v */
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "tbdi_map.vh"
// Overview of operation
// - red led dark without error, flashing with one
// - green led only when fault free, fieldbus running
// - red led uses fast and slow blink rates
// - start burst, code train, pause, argument train
// - argument counts terminals before the fault
// - passive terminals are skipped in that count
// - command error: three pulses, argument zero
// - data error: four pulses, break position argument
// - register fault: five pulses, terminal position
// - internal error: six pulses, argument zero/one/eight
// - length mismatch: seven pulses, argument zero
// - some errors stay lit until power cycle
// - state word zero means synchronous, error free
// - nonzero may only mean bus slower than task
// - bits 0,1,2: error, config change, lengths
// - bits 8,9,10: no inputs, update busy flags
// - bit 11 watchdog, bit 15 acyclic function
// - reset request clears non-sticky error, restarts bus
// - link led off, steady, or flashing on traffic
module tbdi_top #(
	parameter        NTERM     = 64,
	parameter [31:0] FAST_HALF = `TBDI_MS_CYC(`TBDI_FAST_HALF_MS),
	parameter [31:0] SLOW_HALF = `TBDI_MS_CYC(`TBDI_SLOW_HALF_MS),
	parameter [31:0] PAUSE_CYC = `TBDI_MS_CYC(`TBDI_PAUSE_MS),
	parameter [31:0] LA_HALF   = `TBDI_MS_CYC(`TBDI_LA_HALF_MS),
	parameter [31:0] LA_HOLD   = `TBDI_MS_CYC(`TBDI_LA_HOLD_MS)
) (
	// ******
	// clock, reset, enable
	// ******
	input  wire             clk_sys_in,
	input  wire             rstn_in,
	input  wire             clken_in,
	// ******
	// avalon-mm slave
	// ******
	input  wire [3:0]       avs_address_in,
	input  wire             avs_read_in,
	input  wire             avs_write_in,
	input  wire [31:0]      avs_writedata_in,
	input  wire [3:0]       avs_byteenable_in,
	output reg  [31:0]      avs_readdata_out,
	output wire             avs_waitrequest_out,
	// ******
	// terminal bus engine status
	// ******
	input  wire             bus_run_in,
	input  wire             bus_err_in,
	input  wire             cfg_chg_in,
	input  wire             len_mis_in,
	input  wire             no_valid_in,
	input  wire             in_upd_busy_in,
	input  wire             out_upd_busy_in,
	input  wire             wdog_in,
	input  wire             acyclic_in,
	input  wire             fieldbus_ok_in,
	// ******
	// error events from the terminal chain
	// ******
	input  wire             err_evt_in,
	input  wire [2:0]       err_kind_in,
	input  wire [7:0]       err_pos_in,
	input  wire [NTERM-1:0] term_passive_in,
	// ******
	// frame bus link
	// ******
	input  wire             frame_mode_in,
	input  wire             frame_link_in,
	input  wire             frame_traffic_in,
	// ******
	// leds and bus restart
	// ******
	output wire             led_err_out,
	output reg              led_run_out,
	output wire             led_la_out,
	output reg              bus_restart_out
);
	// ******
	// active terminal count up to a position
	// ******
	// passive terminals (power feeds) take no place
	function [7:0] active_upto;
		input [7:0]       pos;
		input [NTERM-1:0] passive;
		integer i;
		reg [7:0] cnt;
		begin
			cnt = 8'h00;
			for (i = 0; i < NTERM; i = i + 1) begin
				if ((i < pos) && !passive[i]) begin
					cnt = cnt + 8'h01;
				end
			end
			active_upto = cnt;
		end
	endfunction

	// ******
	// event decode
	// ******
	reg  [3:0] ev_code;   // code pulses for event
	reg  [7:0] ev_arg;    // argument pulses for event
	reg        ev_sticky; // survives reset request
	reg        ev_emc;    // uncoded flashing

	// map each event kind to its report
	always @* begin
		ev_code   = `TBDI_C_CMD;
		ev_arg    = `TBDI_A_ZERO;
		ev_sticky = 1'b0;
		ev_emc    = 1'b0;
		case (err_kind_in)
		`TBDI_K_CMD: begin
			// no terminal inserted, bad command
			ev_code = `TBDI_C_CMD;
		end
		`TBDI_K_DATA: begin
			// 0 means break right behind the unit
			ev_code = `TBDI_C_DATA;
			ev_arg  = active_upto(err_pos_in,
				term_passive_in);
		end
		`TBDI_K_REG: begin
			ev_code = `TBDI_C_REG;
			ev_arg  = active_upto(err_pos_in,
				term_passive_in);
		end
		`TBDI_K_INIT: begin
			ev_code   = `TBDI_C_INT;
			ev_sticky = 1'b1;
		end
		`TBDI_K_INT1: begin
			ev_code   = `TBDI_C_INT;
			ev_arg    = `TBDI_A_INT1;
			ev_sticky = 1'b1;
		end
		`TBDI_K_INT8: begin
			ev_code   = `TBDI_C_INT;
			ev_arg    = `TBDI_A_INT8;
			ev_sticky = 1'b1;
		end
		`TBDI_K_LEN: begin
			ev_code = `TBDI_C_LEN;
		end
		default: begin
			// emc trouble has no code of its own
			ev_emc = 1'b1;
		end
		endcase
	end

	// ******
	// bus slave handshake
	// ******
	reg         ack_r;   // second cycle of an access
	reg         rst_req; // reset request write
	wire        req     = avs_read_in | avs_write_in;
	// accepted only when the enable lets state move
	wire        take    = req & ack_r & clken_in;
	wire        wr_take = take & avs_write_in;

	assign avs_waitrequest_out = req & ~(ack_r & clken_in);

	// a write of one to the request bit, low lane
	always @* begin
		rst_req = wr_take
			&& (avs_address_in == `TBDI_OFS_CTRL)
			&& avs_byteenable_in[0]
			&& avs_writedata_in[`TBDI_CTRL_RST];
	end

	// ******
	// latched error report
	// ******
	reg        err_act_r;    // an error is being shown
	reg        err_sticky_r; // only power cycle clears
	reg        err_emc_r;    // continuous flashing
	reg  [3:0] err_code_r;
	reg  [7:0] err_arg_r;
	// sticky errors replace ordinary ones, not the reverse
	wire       clr_ok  = rst_req & ~err_sticky_r;
	wire       ev_take = err_evt_in
		& (~err_act_r | clr_ok | (ev_sticky & ~err_sticky_r));

	// first error is kept so the count stays readable
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			err_act_r    <= 1'b0;
			err_sticky_r <= 1'b0;
			err_emc_r    <= 1'b0;
			err_code_r   <= 4'h0;
			err_arg_r    <= 8'h00;
		end else if (clken_in) begin
			if (ev_take) begin
				// new event wins over a same-cycle clear
				err_act_r    <= 1'b1;
				err_sticky_r <= ev_sticky;
				err_emc_r    <= ev_emc;
				err_code_r   <= ev_code;
				err_arg_r    <= ev_arg;
			end else if (clr_ok) begin
				err_act_r <= 1'b0;
				err_emc_r <= 1'b0;
			end
		end
	end

	// ******
	// bus restart and state word
	// ******
	reg  [15:0] state_word_r; // terminal_bus_state_word

	// restart pulse follows the accepted request
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_restart_out <= 1'b0;
		end else if (clken_in) begin
			bus_restart_out <= rst_req;
		end
	end

	// snapshot of bus health; busy bits may only mean
	// the bus cycle outruns the task, not a real fault
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_word_r <= 16'h0000;
		end else if (clken_in) begin
			state_word_r <= 16'h0000;
			state_word_r[`TBDI_SW_BUS_ERR] <=
				bus_err_in | err_act_r;
			state_word_r[`TBDI_SW_CFG_CHG] <= cfg_chg_in;
			state_word_r[`TBDI_SW_LEN_MIS] <= len_mis_in
				| (err_act_r
				& (err_code_r == `TBDI_C_LEN));
			state_word_r[`TBDI_SW_NO_IN]   <= no_valid_in;
			state_word_r[`TBDI_SW_IN_UPD]  <=
				in_upd_busy_in;
			state_word_r[`TBDI_SW_OUT_UPD] <=
				out_upd_busy_in;
			state_word_r[`TBDI_SW_WDOG]    <= wdog_in;
			state_word_r[`TBDI_SW_ACYC]    <=
				acyclic_in | bus_restart_out;
		end
	end

	// ******
	// green run led
	// ******
	// lit only with the bus up, fieldbus up, no flags
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			led_run_out <= 1'b0;
		end else if (clken_in) begin
			led_run_out <= bus_run_in & fieldbus_ok_in
				& ~err_act_r
				& (state_word_r == 16'h0000);
		end
	end

	// ******
	// register read path
	// ******
	reg  [31:0] rd_mux; // decoded read value

	// unmapped offsets and the ctrl register read zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address_in)
		`TBDI_OFS_STATE: begin
			rd_mux[15:0] = state_word_r;
		end
		`TBDI_OFS_ERR: begin
			rd_mux[`TBDI_ERR_CODE_LO +: 4] = err_code_r;
			rd_mux[`TBDI_ERR_ARG_LO +: 8]  = err_arg_r;
			rd_mux[`TBDI_ERR_ACT]    = err_act_r;
			rd_mux[`TBDI_ERR_STICKY] = err_sticky_r;
			rd_mux[`TBDI_ERR_EMC]    = err_emc_r;
		end
		default: begin
			rd_mux = 32'h0000_0000;
		end
		endcase
	end

	// first cycle of an access loads data, second ends it
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_r            <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end else if (clken_in) begin
			if (take) begin
				ack_r <= 1'b0;
			end else if (req) begin
				ack_r <= 1'b1;
				if (avs_read_in) begin
					avs_readdata_out <= rd_mux;
				end
			end
		end
	end

	// ******
	// led drivers
	// ******
	// coded report on the red led
	tbdi_blink #(
		.FAST_HALF (FAST_HALF),
		.SLOW_HALF (SLOW_HALF),
		.PAUSE_CYC (PAUSE_CYC),
		.START_N   (`TBDI_START_PULSES)
	) u_blink (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.clken_in   (clken_in),
		.active_in  (err_act_r),
		.cont_in    (err_emc_r),
		.code_in    (err_code_r),
		.arg_in     (err_arg_r),
		.led_out    (led_err_out)
	);

	// link / activity led for frame bus mode
	tbdi_la_led #(
		.HALF_CYC (LA_HALF),
		.HOLD_CYC (LA_HOLD)
	) u_la (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.clken_in   (clken_in),
		.mode_in    (frame_mode_in),
		.link_in    (frame_link_in),
		.traffic_in (frame_traffic_in),
		.led_out    (led_la_out)
	);
endmodule // tbdi_top

/* common/tbdi_map.vh */
`ifndef TBDI_MAP_VH
`define TBDI_MAP_VH
// ******
// clock and timing
// ******
`define TBDI_CLK_MHZ      250
`define TBDI_FAST_HALF_MS 25
`define TBDI_SLOW_HALF_MS 250
`define TBDI_PAUSE_MS     1000
`define TBDI_LA_HALF_MS   50
`define TBDI_LA_HOLD_MS   200
`define TBDI_START_PULSES 8
// milliseconds to clock cycles
`define TBDI_MS_CYC(ms) ((ms) * 1000 * `TBDI_CLK_MHZ)
// ******
// register offsets (byte addresses)
// ******
`define TBDI_OFS_STATE  4'h0
`define TBDI_OFS_CTRL   4'h4
`define TBDI_OFS_ERR    4'h8
// ctrl fields
`define TBDI_CTRL_RST   0
// error status fields
`define TBDI_ERR_CODE_LO 0
`define TBDI_ERR_ARG_LO  8
`define TBDI_ERR_ACT     16
`define TBDI_ERR_STICKY  17
`define TBDI_ERR_EMC     18
// ******
// state word bits
// ******
`define TBDI_SW_BUS_ERR  0
`define TBDI_SW_CFG_CHG  1
`define TBDI_SW_LEN_MIS  2
`define TBDI_SW_NO_IN    8
`define TBDI_SW_IN_UPD   9
`define TBDI_SW_OUT_UPD  10
`define TBDI_SW_WDOG     11
`define TBDI_SW_ACYC     15
// ******
// error event kinds and reported codes
// ******
`define TBDI_K_CMD   3'h0
`define TBDI_K_DATA  3'h1
`define TBDI_K_REG   3'h2
`define TBDI_K_INIT  3'h3
`define TBDI_K_INT1  3'h4
`define TBDI_K_INT8  3'h5
`define TBDI_K_LEN   3'h6
`define TBDI_K_EMC   3'h7
`define TBDI_C_CMD   4'h3
`define TBDI_C_DATA  4'h4
`define TBDI_C_REG   4'h5
`define TBDI_C_INT   4'h6
`define TBDI_C_LEN   4'h7
`define TBDI_A_ZERO  8'h00
`define TBDI_A_INT1  8'h01
`define TBDI_A_INT8  8'h08
`endif

/* src/tbdi_blink.v */
`timescale 1ns/10ps
`include "tbdi_map.vh"
// ******
// coded blink sequencer for the red error led
// ******
module tbdi_blink #(
	parameter [31:0] FAST_HALF = 32'h0000_0010, // fast half period
	parameter [31:0] SLOW_HALF = 32'h0000_0040, // slow half period
	parameter [31:0] PAUSE_CYC = 32'h0000_0100, // dark pause
	parameter [7:0]  START_N   = 8'h08          // start burst pulses
) (
	input  wire       clk_sys_in,
	input  wire       rstn_in,
	input  wire       clken_in,
	input  wire       active_in, // an error is latched
	input  wire       cont_in,   // uncoded continuous flashing
	input  wire [3:0] code_in,
	input  wire [7:0] arg_in,
	output reg        led_out
);
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_CODE  = 3'h2;
	localparam [2:0] ST_PAUSE = 3'h3;
	localparam [2:0] ST_ARG   = 3'h4;
	localparam [2:0] ST_GAP   = 3'h5;
	localparam [2:0] ST_CONT  = 3'h6;

	reg  [2:0]  st_r;    // sequence phase
	reg  [31:0] tmr_r;   // cycles left in this half
	reg  [7:0]  left_r;  // pulses left in train
	reg         off_r;   // in dark half of a pulse
	wire [31:0] fast_ld = FAST_HALF - 32'h0000_0001;
	wire [31:0] slow_ld = SLOW_HALF - 32'h0000_0001;
	wire [31:0] half_ld = (st_r == ST_START) ? fast_ld : slow_ld;

	// one process walks the whole report
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r    <= ST_IDLE;
			tmr_r   <= 32'h0000_0000;
			left_r  <= 8'h00;
			off_r   <= 1'b0;
			led_out <= 1'b0;
		end else if (clken_in) begin
			if (!active_in) begin
				// no error: dark and rearmed
				st_r    <= ST_IDLE;
				tmr_r   <= 32'h0000_0000;
				led_out <= 1'b0;
			end else if (tmr_r != 32'h0000_0000) begin
				tmr_r <= tmr_r - 32'h0000_0001;
			end else begin
				case (st_r)
				ST_IDLE: begin
					off_r   <= 1'b0;
					led_out <= 1'b1;
					if (cont_in) begin
						st_r  <= ST_CONT;
						tmr_r <= fast_ld;
					end else begin
						st_r   <= ST_START;
						left_r <= START_N;
						tmr_r  <= fast_ld;
					end
				end
				ST_START, ST_CODE, ST_ARG: begin
					if (!off_r) begin
						// lit half done, go dark
						led_out <= 1'b0;
						off_r   <= 1'b1;
						tmr_r   <= half_ld;
					end else if (left_r > 8'h01) begin
						left_r  <= left_r - 8'h01;
						led_out <= 1'b1;
						off_r   <= 1'b0;
						tmr_r   <= half_ld;
					end else begin
						// train finished
						case (st_r)
						ST_START: begin
							st_r    <= ST_CODE;
							left_r  <= {4'h0, code_in};
							led_out <= 1'b1;
							off_r   <= 1'b0;
							tmr_r   <= slow_ld;
						end
						ST_CODE: begin
							st_r  <= ST_PAUSE;
							tmr_r <= PAUSE_CYC - 32'h0000_0001;
						end
						default: begin
							st_r  <= ST_GAP;
							tmr_r <= PAUSE_CYC - 32'h0000_0001;
						end
						endcase
					end
				end
				ST_PAUSE: begin
					// argument 0 gives no pulses at all
					if (arg_in == `TBDI_A_ZERO) begin
						st_r <= ST_GAP;
					end else begin
						st_r    <= ST_ARG;
						left_r  <= arg_in;
						led_out <= 1'b1;
						off_r   <= 1'b0;
						tmr_r   <= slow_ld;
					end
				end
				ST_CONT: begin
					// emc: plain fast flashing
					led_out <= ~led_out;
					tmr_r   <= fast_ld;
					if (!cont_in) begin
						st_r <= ST_IDLE;
					end
				end
				default: begin
					// gap over: report again
					st_r <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // tbdi_blink

/* src/tbdi_la_led.v */
`timescale 1ns/10ps
`include "tbdi_map.vh"
// ******
// link / activity led of the frame bus
// ******
module tbdi_la_led #(
	parameter [31:0] HALF_CYC = 32'h0000_0010, // flash half period
	parameter [31:0] HOLD_CYC = 32'h0000_0040  // traffic stretch
) (
	input  wire clk_sys_in,
	input  wire rstn_in,
	input  wire clken_in,
	input  wire mode_in,    // frame bus selected
	input  wire link_in,    // bus connected
	input  wire traffic_in, // data seen this cycle
	output reg  led_out
);
	reg [31:0] hold_r; // stretches short bursts
	reg [31:0] tgl_r;  // flash half counter
	reg        ph_r;   // flash phase

	// traffic stretch keeps single frames visible
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_r  <= 32'h0000_0000;
			tgl_r   <= 32'h0000_0000;
			ph_r    <= 1'b0;
			led_out <= 1'b0;
		end else if (clken_in) begin
			if (traffic_in && link_in) begin
				hold_r <= HOLD_CYC;
			end else if (hold_r != 32'h0000_0000) begin
				hold_r <= hold_r - 32'h0000_0001;
			end
			if (tgl_r == 32'h0000_0000) begin
				tgl_r <= HALF_CYC - 32'h0000_0001;
				ph_r  <= ~ph_r;
			end else begin
				tgl_r <= tgl_r - 32'h0000_0001;
			end
			if (!mode_in || !link_in) begin
				led_out <= 1'b0;
			end else if (hold_r != 32'h0000_0000) begin
				led_out <= ph_r;
			end else begin
				led_out <= 1'b1;
			end
		end
	end
endmodule // tbdi_la_led

/* tb/tbdi_top_sva.sv */
`timescale 1ns/10ps
// ******
// port checker for the diagnostic indicator
// ******
module tbdi_top_sva #(
	parameter [31:0] SLOW_HALF = 32'h0000_0040,
	parameter [31:0] PAUSE_CYC = 32'h0000_0100,
	parameter [31:0] LA_HOLD   = 32'h0000_0040
) (
	input wire        clk_sys_in,
	input wire        rstn_in,
	input wire        clken_in,
	input wire [3:0]  avs_address_in,
	input wire        avs_read_in,
	input wire        avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0]  avs_byteenable_in,
	input wire [31:0] avs_readdata_out,
	input wire        avs_waitrequest_out,
	input wire        bus_run_in,
	input wire        fieldbus_ok_in,
	input wire        err_evt_in,
	input wire [2:0]  err_kind_in,
	input wire        frame_mode_in,
	input wire        frame_link_in,
	input wire        frame_traffic_in,
	input wire        led_err_out,
	input wire        led_run_out,
	input wire        led_la_out,
	input wire        bus_restart_out
);
	reg        act_r;    // an error should be latched
	reg        sticky_r; // only power loss clears it
	reg [31:0] dark_r;   // dark run while latched
	reg [31:0] quiet_r;  // linked cycles without traffic
	wire evt = err_evt_in & clken_in;
	wire stk = (err_kind_in >= 3'h3) && (err_kind_in <= 3'h5);
	// shadow of the error latch, one edge late on clear
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			act_r <= 1'b0;
			sticky_r <= 1'b0;
			dark_r <= 32'h0000_0000;
			quiet_r <= 32'h0000_0000;
		end else begin
			if (evt) begin
				act_r <= 1'b1;
				sticky_r <= sticky_r | stk;
			end else if (bus_restart_out) begin
				act_r <= sticky_r;
			end
			dark_r <= (act_r && !led_err_out) ? dark_r + 1 : 0;
			quiet_r <= (frame_mode_in && frame_link_in &&
				!frame_traffic_in) ? quiet_r + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	a_wait_one: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out && clken_in |=> !avs_waitrequest_out)
		else $error("access waited too long");
	a_state_layout: assert property (avs_read_in &&
		!avs_waitrequest_out && avs_address_in == 4'h0 |->
		avs_readdata_out[31:16] == 16'h0000 &&
		avs_readdata_out[7:3] == 5'h00 &&
		avs_readdata_out[14:12] == 3'h0)
		else $error("state word has stray bits");
	a_restart_pulse: assert property (avs_write_in &&
		!avs_waitrequest_out && avs_address_in == 4'h4 &&
		avs_writedata_in[0] && avs_byteenable_in[0] |=>
		bus_restart_out ##1 !bus_restart_out)
		else $error("restart pulse missing");
	a_dark_idle: assert property ((!act_r)[*3] |-> !led_err_out)
		else $error("error led lit without error");
	a_flash_bound: assert property (
		dark_r <= PAUSE_CYC + PAUSE_CYC + SLOW_HALF + 8)
		else $error("error led dark too long");
	a_err_prompt: assert property (evt && !act_r |->
		##[1:10] led_err_out)
		else $error("error led slow to start");
	a_run_cond: assert property (led_run_out |->
		$past(bus_run_in) && $past(fieldbus_ok_in))
		else $error("run led without running bus");
	a_la_off: assert property (
		!(frame_mode_in && frame_link_in) |=> !led_la_out)
		else $error("link led lit without link");
	a_la_steady: assert property (quiet_r > LA_HOLD + 3
		|-> led_la_out)
		else $error("link led not steady");
	c_restart: cover property (bus_restart_out);
	c_new_err: cover property (evt && !act_r);
	c_la_flash: cover property (frame_traffic_in && !led_la_out);
endmodule // tbdi_top_sva

bind tbdi_top tbdi_top_sva #(.SLOW_HALF(SLOW_HALF),
	.PAUSE_CYC(PAUSE_CYC), .LA_HOLD(LA_HOLD)) u_sva (.clk_sys_in,
	.rstn_in, .clken_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
	.avs_waitrequest_out, .bus_run_in, .fieldbus_ok_in, .err_evt_in,
	.err_kind_in, .frame_mode_in, .frame_link_in, .frame_traffic_in,
	.led_err_out, .led_run_out, .led_la_out, .bus_restart_out);

/* tb/tbdi_chain_model.sv */
`timescale 1ns/10ps
// ******
// terminal chain: error events and passive slots
// ******
module tbdi_chain_model (
	input  wire        clk_sys_in,
	input  wire        rstn_in,
	input  wire        fire_in,    // raise one event
	input  wire [2:0]  kind_in,
	input  wire [7:0]  pos_in,
	input  wire [63:0] passive_in, // power feed slots
	output reg         err_evt_out,
	output reg  [2:0]  err_kind_out,
	output reg  [7:0]  err_pos_out,
	output wire [63:0] term_passive_out
);
	// rail build is fixed for the run
	assign term_passive_out = passive_in;
	// kind and position scramble once the pulse is gone
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			err_evt_out <= 1'b0;
			err_kind_out <= 3'h0;
			err_pos_out <= 8'h00;
		end else if (fire_in) begin
			err_evt_out <= 1'b1;
			err_kind_out <= kind_in;
			err_pos_out <= pos_in;
		end else begin
			err_evt_out <= 1'b0;
			err_kind_out <= ~err_kind_out;
			err_pos_out <= ~err_pos_out;
		end
	end
endmodule // tbdi_chain_model

/* tb/testbench.sv */
`timescale 1ns/10ps
`include "tbdi_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
	localparam [31:0] FH = 32'h0000_0004; // fast half
	localparam [31:0] SH = 32'h0000_0008; // slow half
	localparam [31:0] LD = 32'h0000_0010; // traffic hold
	int failures, checks;
	logic clk_sys_in, rstn_in, clken_in, avs_read_in, avs_write_in;
	logic [3:0]  avs_address_in, avs_byteenable_in;
	logic [31:0] avs_writedata_in;
	wire  [31:0] avs_readdata_out;
	wire  avs_waitrequest_out, led_err_out, led_run_out, led_la_out;
	wire  bus_restart_out, err_evt_in;
	wire  [2:0]  err_kind_in;
	wire  [7:0]  err_pos_in;
	wire  [63:0] term_passive_in;
	logic bus_run_in, fieldbus_ok_in, fire;
	logic frame_mode_in, frame_link_in, frame_traffic_in;
	logic [7:0]  st, pos; // status levels, event place
	logic [2:0]  kind;
	// short timing keeps a report to a few hundred cycles
	tbdi_top #(.FAST_HALF(FH), .SLOW_HALF(SH),
		.PAUSE_CYC(32'h0000_0010), .LA_HALF(FH), .LA_HOLD(LD)) DUT (
		.clk_sys_in, .rstn_in, .clken_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in,
		.avs_readdata_out, .avs_waitrequest_out, .bus_run_in,
		.bus_err_in(st[0]), .cfg_chg_in(st[1]), .len_mis_in(st[2]),
		.no_valid_in(st[3]), .in_upd_busy_in(st[4]),
		.out_upd_busy_in(st[5]), .wdog_in(st[6]), .acyclic_in(st[7]),
		.fieldbus_ok_in, .err_evt_in, .err_kind_in, .err_pos_in,
		.term_passive_in, .frame_mode_in, .frame_link_in,
		.frame_traffic_in, .led_err_out, .led_run_out, .led_la_out,
		.bus_restart_out);
	// terminals 1 and 3 are passive
	tbdi_chain_model u_chain (.clk_sys_in, .rstn_in, .fire_in(fire),
		.kind_in(kind), .pos_in(pos),
		.passive_in(64'h0000_0000_0000_000a), .err_evt_out(err_evt_in),
		.err_kind_out(err_kind_in), .err_pos_out(err_pos_in),
		.term_passive_out(term_passive_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// one bus access, held until wait drops
	task automatic av(input bit wr, input [3:0] a, input [31:0] wd,
		output [31:0] rd);
		int n;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 64);
		if (n >= 64) failures++;
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic rdchk(input [3:0] a, input [31:0] e, input string n);
		logic [31:0] d;
		av(1'b0, a, 32'h0000_0000, d);
		`CHK(n, e, d)
	endtask
	task automatic wr(input [3:0] a, input [31:0] d);
		logic [31:0] x;
		av(1'b1, a, d, x);
	endtask
	task automatic do_reset;
		@(posedge clk_sys_in);
		rstn_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		repeat (2) @(negedge clk_sys_in);
	endtask
	task automatic inject(input [2:0] k, input [7:0] p);
		@(posedge clk_sys_in);
		fire <= 1'b1;
		kind <= k;
		pos <= p;
		@(posedge clk_sys_in);
		fire <= 1'b0;
		repeat (3) @(negedge clk_sys_in);
	endtask
	// lit run length, then dark run length
	task automatic pulse(output int hi, output int lo);
		int n;
		n = 0;
		while (led_err_out !== 1'b1 && n < 400) begin
			@(negedge clk_sys_in);
			n++;
		end
		hi = 0;
		while (led_err_out === 1'b1) begin
			@(negedge clk_sys_in);
			hi++;
		end
		lo = 0;
		while (led_err_out !== 1'b1 && lo < 100) begin
			@(negedge clk_sys_in);
			lo++;
		end
	endtask
	// sync on a full fast burst, then count both slow trains
	task automatic decode(output int code, output int arg);
		int hi, lo, f;
		f = 0;
		while (f < 8) begin
			pulse(hi, lo);
			f = (hi > 0 && hi < SH) ? f + 1 : 0;
		end
		`CHK("fast half", FH, hi)
		code = 0;
		do begin
			pulse(hi, lo);
			`CHK("slow half", SH, hi)
			code++;
		end while (lo <= SH);
		arg = 0;
		pulse(hi, lo);
		while (hi >= SH) begin
			arg++;
			if (lo > SH) break;
			pulse(hi, lo);
		end
	endtask
	task automatic t_idle;
		`CHK("err led", 1'b0, led_err_out)
		`CHK("run led", 1'b1, led_run_out)
		rdchk(4'h0, 32'h0000_0000, "state");
		rdchk(4'h4, 32'h0000_0000, "ctrl");
		wr(4'h0, 32'hffff_ffff);
		wr(4'hc, 32'hffff_ffff);
		rdchk(4'h0, 32'h0000_0000, "state ro");
		rdchk(4'hc, 32'h0000_0000, "unmapped");
		$display("test idle done");
	endtask
	task automatic t_state;
		int bp[8] = '{0, 1, 2, 8, 9, 10, 11, 15};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys_in);
			st <= 8'h01 << i;
			repeat (3) @(negedge clk_sys_in);
			`CHK("run led off", 1'b0, led_run_out)
			rdchk(4'h0, 32'h0000_0001 << bp[i], "state bit");
		end
		@(posedge clk_sys_in);
		st <= 8'h00;
		fieldbus_ok_in <= 1'b0;
		repeat (3) @(negedge clk_sys_in);
		`CHK("run led fb", 1'b0, led_run_out)
		@(posedge clk_sys_in);
		fieldbus_ok_in <= 1'b1;
		repeat (3) @(negedge clk_sys_in);
		`CHK("run led back", 1'b1, led_run_out)
		$display("test state done");
	endtask
	task automatic t_codes;
		logic [2:0] k[8] = '{`TBDI_K_CMD, `TBDI_K_DATA, `TBDI_K_DATA,
			`TBDI_K_REG, `TBDI_K_LEN, `TBDI_K_INIT, `TBDI_K_INT1,
			`TBDI_K_INT8};
		logic [7:0] p[8] = '{8'h07, 8'h00, 8'h05, 8'h04, 8'h03, 8'h02,
			8'h02, 8'h02};
		int c[8] = '{3, 4, 4, 5, 7, 6, 6, 6};
		int a[8] = '{0, 0, 3, 2, 0, 0, 1, 8};
		int gc, ga;
		logic [31:0] e;
		for (int i = 0; i < 8; i++) begin
			inject(k[i], p[i]);
			if (i == 0) inject(`TBDI_K_DATA, 8'h05); // refused
			e = {14'h0000, i > 4, 1'b1, a[i][7:0], 4'h0, c[i][3:0]};
			rdchk(4'h8, e, "err reg");
			decode(gc, ga);
			`CHK("code pulses", c[i], gc)
			`CHK("arg pulses", a[i], ga)
			`CHK("run led err", 1'b0, led_run_out)
			wr(4'h4, 32'h0000_0001);
			`CHK("restart", 1'b1, bus_restart_out)
			rdchk(4'h8, i > 4 ? e : e ^ 32'h0001_0000, "err clr");
			if (i > 4) do_reset;
		end
		$display("test codes done");
	endtask
	task automatic t_emc;
		int hi, lo;
		logic [31:0] d;
		inject(`TBDI_K_EMC, 8'h00);
		av(1'b0, 4'h8, 32'h0000_0000, d);
		`CHK("emc flag", 3'h5, d[18:16])
		pulse(hi, lo);
		repeat (3) begin
			pulse(hi, lo);
			`CHK("emc hi", FH, hi)
			`CHK("emc lo", FH, lo)
		end
		@(posedge clk_sys_in);
		clken_in <= 1'b0;
		repeat (6) @(negedge clk_sys_in);
		`CHK("emc frozen", 1'b1, led_err_out)
		@(posedge clk_sys_in);
		clken_in <= 1'b1;
		wr(4'h4, 32'h0000_0001);
		rdchk(4'h8, {28'h0, `TBDI_C_CMD}, "emc clr");
		$display("test emc done");
	endtask
	task automatic t_link;
		int n;
		@(posedge clk_sys_in);
		frame_mode_in <= 1'b1;
		repeat (4) @(negedge clk_sys_in);
		`CHK("la unlinked", 1'b0, led_la_out)
		@(posedge clk_sys_in);
		frame_link_in <= 1'b1;
		repeat (LD + 4) @(negedge clk_sys_in);
		`CHK("la steady", 1'b1, led_la_out)
		n = 0;
		repeat (40) begin
			@(posedge clk_sys_in);
			frame_traffic_in <= ~frame_traffic_in;
			@(negedge clk_sys_in);
			n += (led_la_out === 1'b0);
		end
		`CHK("la flash", 1'b1, n > 8)
		@(posedge clk_sys_in);
		frame_traffic_in <= 1'b0;
		frame_mode_in <= 1'b0;
		repeat (3) @(negedge clk_sys_in);
		`CHK("la off", 1'b0, led_la_out)
		$display("test link done");
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// cut a hang short
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		failures++;
		conclude;
	end
	initial begin
		failures = 0;
		checks = 0;
		{rstn_in, avs_read_in, avs_write_in, fire} = 4'h0;
		{frame_mode_in, frame_link_in, frame_traffic_in} = 3'h0;
		{clken_in, bus_run_in, fieldbus_ok_in} = 3'h7;
		avs_address_in = 4'h0;
		avs_byteenable_in = 4'hf;
		avs_writedata_in = 32'h0000_0000;
		{st, pos, kind} = 19'h0_0000;
		do_reset;
		t_idle;
		t_state;
		t_codes;
		t_emc;
		t_link;
		conclude;
	end
endmodule // testbench
